// ---- hw/lxt_pkg.sv ----
// Constants, field layout and timing figures of the line exposure timing block.
package lxt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses).
    localparam logic [7:0] CTRL_OFFSET          = 8'h00;
    localparam logic [7:0] COUNT_OFFSET         = 8'h04;
    localparam logic [7:0] DURATION_OFFSET      = 8'h08;
    localparam logic [7:0] COMMAND_OFFSET       = 8'h0c;
    localparam logic [7:0] DEBOUNCE_BASE_OFFSET = 8'h10;
    localparam logic [7:0] STATUS_OFFSET        = 8'h1c;

    ////////////////////////////////////////////////////////////////////////////
    // Control field positions.
    localparam int TRIG_ENABLE_BIT  = 0;
    localparam int PULSE_MODE_BIT   = 1;
    localparam int FALLING_EDGE_BIT = 2;
    localparam int ORIGIN_LSB       = 4;
    localparam int SW_TRIGGER_BIT   = 0;

    // Status field positions.
    localparam int STAT_ACTIVE_BIT  = 0;
    localparam int STAT_START_BIT   = 1;
    localparam int STAT_END_BIT     = 2;
    localparam int STAT_ARMED_BIT   = 3;
    localparam int STAT_RANGE_BIT   = 4;
    localparam int STAT_LINES_LSB   = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger origin encoding.
    localparam logic [1:0] ORIGIN_SOFTWARE = 2'h0;
    localparam logic [1:0] ORIGIN_LINE1    = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [1:0]  ORIGIN_RESET   = ORIGIN_LINE1;
    localparam logic [11:0] COUNT_RESET    = 12'h1f4;
    localparam logic [11:0] DEBOUNCE_RESET = 12'h000;

    // Exposure count limits and unit of the absolute setting (10 ns steps).
    localparam logic [11:0] COUNT_MIN         = 12'h001;
    localparam logic [11:0] COUNT_MAX         = 12'hfff;
    localparam int          ABS_UNITS_PER_TICK = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Times as printed, and the cycle and tick counts derived from them.
    localparam int CLK_PERIOD_PS       = 4000;
    localparam int TIMEBASE_NS         = 100;
    localparam int BASE_START_DELAY_NS = 1500;
    localparam int BASE_END_DELAY_NS   = 1200;
    localparam int MIN_EXPOSURE_NS     = 2000;
    localparam int MAX_EXPOSURE_US     = 10000;

    localparam int TICK_CYCLES        = (TIMEBASE_NS * 1000) / CLK_PERIOD_PS;
    localparam int START_DELAY_TICKS  = BASE_START_DELAY_NS / TIMEBASE_NS;
    localparam int END_DELAY_TICKS    = BASE_END_DELAY_NS / TIMEBASE_NS;
    localparam int MIN_EXPOSURE_TICKS = (MIN_EXPOSURE_NS + TIMEBASE_NS - 1) / TIMEBASE_NS;
    localparam int MAX_EXPOSURE_TICKS = (MAX_EXPOSURE_US * 1000) / TIMEBASE_NS;

endpackage : lxt_pkg

// ---- hw/lxt_sync.sv ----
// Three-stage synchroniser that accepts a level once the last two stages agree.
`timescale 1ns/10ps
`default_nettype none

module lxt_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Asynchronous pin level
    input  wire logic pin_level,
    // Accepted level in the core clock domain
    output logic      level_q
);

    logic meta_q;
    logic stage2_q;
    logic stage3_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
        end else begin
            meta_q   <= pin_level;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    // A change counts only when the second and third stages agree.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            level_q <= 1'b0;
        end else if (stage2_q == stage3_q) begin
            level_q <= stage3_q;
        end
    end

endmodule : lxt_sync

`default_nettype wire

// ---- hw/lxt_exposure.sv ----
// Line exposure timing: trigger selection, exposure settings and exposure window.
`timescale 1ns/10ps
`default_nettype none

module lxt_exposure (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Internal line start used while line-start triggering is off
    input  wire logic        internal_line_start,
    // External trigger input lines 1 to 3
    input  wire logic [2:0]  external_line_trigger,
    // Exposure window
    output logic             exposure_active,
    output logic             exposure_start,
    output logic             exposure_end
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Clamp a count into the accepted raw range.
    function automatic logic [11:0] clamp_count(input logic [12:0] value);
        logic [11:0] result;
        result = value[11:0];
        if (value[12]) begin
            result = lxt_pkg::COUNT_MAX;
        end else if (value[11:0] < lxt_pkg::COUNT_MIN) begin
            result = lxt_pkg::COUNT_MIN;
        end
        return result;
    endfunction : clamp_count

    // Map a register address to a debounce slot, or 3 when it is none.
    function automatic logic [1:0] debounce_slot(input logic [7:0] addr);
        logic [1:0] slot;
        slot = 2'h3;
        for (int i = 0; i < 3; i++) begin
            if (addr == lxt_pkg::DEBOUNCE_BASE_OFFSET + 8'(4 * i)) begin
                slot = 2'(i);
            end
        end
        return slot;
    endfunction : debounce_slot

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    logic        trig_enable_q;
    logic        pulse_mode_q;
    logic        falling_edge_q;
    logic [1:0]  origin_q;
    logic [11:0] count_q;
    logic [11:0] debounce_q [3];
    logic        sw_trigger_q;

    logic [16:0] rounded_abs;
    logic [12:0] abs_count;
    logic [1:0]  wr_slot;

    // Absolute setting in 10 ns units, rounded half up to the 100 ns grid.
    assign rounded_abs = 17'(reg_wdata[15:0]) + 17'(lxt_pkg::ABS_UNITS_PER_TICK / 2);
    assign abs_count   = 13'(rounded_abs / 17'(lxt_pkg::ABS_UNITS_PER_TICK));
    assign wr_slot     = debounce_slot(reg_addr);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trig_enable_q  <= 1'b0;
            pulse_mode_q   <= 1'b0;
            falling_edge_q <= 1'b0;
            origin_q       <= lxt_pkg::ORIGIN_RESET;
        end else if (reg_write && reg_addr == lxt_pkg::CTRL_OFFSET) begin
            trig_enable_q  <= reg_wdata[lxt_pkg::TRIG_ENABLE_BIT];
            pulse_mode_q   <= reg_wdata[lxt_pkg::PULSE_MODE_BIT];
            falling_edge_q <= reg_wdata[lxt_pkg::FALLING_EDGE_BIT];
            origin_q       <= reg_wdata[lxt_pkg::ORIGIN_LSB +: 2];
        end
    end

    // Raw and absolute settings share one store, so each always reflects the other.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= lxt_pkg::COUNT_RESET;
        end else if (reg_write && reg_addr == lxt_pkg::COUNT_OFFSET) begin
            count_q <= clamp_count(reg_wdata[12:0] | {|reg_wdata[31:13], 12'h000});
        end else if (reg_write && reg_addr == lxt_pkg::DURATION_OFFSET) begin
            count_q <= clamp_count(abs_count | {|reg_wdata[31:16], 12'h000});
        end
    end

    generate
        for (genvar g = 0; g < 3; g++) begin : g_debounce
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    debounce_q[g] <= lxt_pkg::DEBOUNCE_RESET;
                end else if (reg_write && wr_slot == 2'(g)) begin
                    debounce_q[g] <= reg_wdata[11:0];
                end
            end
        end
    endgenerate

    // Software trigger command is a one-cycle pulse.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sw_trigger_q <= 1'b0;
        end else begin
            sw_trigger_q <= reg_write && reg_addr == lxt_pkg::COMMAND_OFFSET
                            && reg_wdata[lxt_pkg::SW_TRIGGER_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input lines: synchronise and detect edges.

    logic [2:0] line_level;
    logic [2:0] line_prev_q;

    generate
        for (genvar g = 0; g < 3; g++) begin : g_line
            lxt_sync u_sync (
                .core_clk  (core_clk),
                .resetn    (resetn),
                .pin_level (external_line_trigger[g]),
                .level_q   (line_level[g])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            line_prev_q <= 3'h0;
        end else begin
            line_prev_q <= line_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger selection and mode decode.

    logic        from_line;
    logic [1:0]  line_idx;
    logic        sel_level;
    logic        sel_prev;
    logic        sel_rise;
    logic        sel_fall;
    logic        active_edge;
    logic        opposite_edge;
    logic        pulse_mode;
    logic        start_req;
    logic [11:0] sel_debounce;

    assign from_line = trig_enable_q && origin_q != lxt_pkg::ORIGIN_SOFTWARE;
    assign line_idx  = 2'(origin_q - lxt_pkg::ORIGIN_LINE1);
    assign sel_level = from_line ? line_level[line_idx] : 1'b0;
    assign sel_prev  = from_line ? line_prev_q[line_idx] : 1'b0;
    assign sel_rise  = sel_level && !sel_prev;
    assign sel_fall  = !sel_level && sel_prev;

    assign active_edge   = falling_edge_q ? sel_fall : sel_rise;
    assign opposite_edge = falling_edge_q ? sel_rise : sel_fall;

    // Software trigger has no width, so pulse-width control needs an input line.
    // mode decision
    assign pulse_mode = from_line && pulse_mode_q;

    always_comb begin
        if (!trig_enable_q) begin
            start_req = internal_line_start;
        end else if (origin_q == lxt_pkg::ORIGIN_SOFTWARE) begin
            start_req = sw_trigger_q;
        end else begin
            start_req = active_edge;
        end
    end

    assign sel_debounce = from_line ? debounce_q[line_idx] : 12'h000;

    ////////////////////////////////////////////////////////////////////////////
    // 100 ns timebase.

    localparam int TICK_W = $clog2(lxt_pkg::TICK_CYCLES);

    logic [TICK_W-1:0] prescale_q;
    logic              tick;
    logic              tick_restart;

    assign tick = prescale_q == TICK_W'(lxt_pkg::TICK_CYCLES - 1);

    // Restarting on each schedule makes every delay whole ticks, never a tick short.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prescale_q <= '0;
        end else if (tick || tick_restart) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + TICK_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delay loads, in ticks.

    logic [13:0] start_load;
    logic [13:0] end_load;
    logic [13:0] timed_end_load;

    always_comb begin
        if (from_line) begin
            start_load = 14'(lxt_pkg::START_DELAY_TICKS) + 14'(sel_debounce);
            end_load   = 14'(lxt_pkg::END_DELAY_TICKS) + 14'(sel_debounce);
        end else begin
            start_load = 14'h0000;
            end_load   = 14'h0000;
        end
    end

    assign timed_end_load = 14'(count_q) + end_load;

    ////////////////////////////////////////////////////////////////////////////
    // Exposure window sequencing.

    logic        start_pend_q;
    logic        end_pend_q;
    logic        armed_q;
    logic        active_q;
    logic [13:0] start_cnt_q;
    logic [13:0] end_cnt_q;
    logic        busy;
    logic        take_start;
    logic        take_width_end;
    logic        start_due;
    logic        end_due;

    // A new line is refused until the previous window has closed.
    assign busy           = start_pend_q || end_pend_q || armed_q || active_q;
    assign take_start     = start_req && !busy;
    assign take_width_end = armed_q && opposite_edge;
    assign tick_restart   = take_start || take_width_end;
    assign start_due      = start_pend_q && (start_cnt_q == 14'h0000 || (tick && start_cnt_q == 14'h0001));
    assign end_due        = end_pend_q && (end_cnt_q == 14'h0000 || (tick && end_cnt_q == 14'h0001));

    // Start delay counter.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            start_pend_q <= 1'b0;
            start_cnt_q  <= 14'h0000;
        end else if (take_start) begin
            start_pend_q <= 1'b1;
            start_cnt_q  <= start_load;
        end else if (start_due) begin
            start_pend_q <= 1'b0;
            start_cnt_q  <= 14'h0000;
        end else if (start_pend_q && tick) begin
            start_cnt_q <= start_cnt_q - 14'h0001;
        end
    end

    // Pulse mode waits for the opposite edge before scheduling the end.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else if (take_start && pulse_mode) begin
            armed_q <= 1'b1;
        end else if (take_width_end || !from_line) begin
            armed_q <= 1'b0;
        end
    end

    // End delay counter.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            end_pend_q <= 1'b0;
            end_cnt_q  <= 14'h0000;
        end else if (take_start && !pulse_mode) begin
            end_pend_q <= 1'b1;
            end_cnt_q  <= timed_end_load;
        end else if (take_width_end) begin
            end_pend_q <= 1'b1;
            end_cnt_q  <= end_load;
        end else if (end_due) begin
            end_pend_q <= 1'b0;
            end_cnt_q  <= 14'h0000;
        end else if (end_pend_q && tick) begin
            end_cnt_q <= end_cnt_q - 14'h0001;
        end
    end

    // Exposure window; an end that falls due in the same cycle as the start wins.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            active_q <= 1'b0;
        end else if (end_due) begin
            active_q <= 1'b0;
        end else if (start_due) begin
            active_q <= 1'b1;
        end
    end

    // Registered one-cycle event pulses.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            exposure_start <= 1'b0;
            exposure_end   <= 1'b0;
        end else begin
            exposure_start <= !active_q && start_due && !end_due;
            exposure_end   <= active_q && end_due;
        end
    end

    assign exposure_active = active_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register read-back.

    logic        range_bad;
    logic [31:0] status_word;
    logic [1:0]  rd_slot;

    assign range_bad = !pulse_mode
                       && (32'(count_q) < 32'(lxt_pkg::MIN_EXPOSURE_TICKS)
                       || 32'(count_q) > 32'(lxt_pkg::MAX_EXPOSURE_TICKS));
    assign rd_slot   = debounce_slot(reg_addr);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[lxt_pkg::STAT_ACTIVE_BIT]    = active_q;
        status_word[lxt_pkg::STAT_START_BIT]     = start_pend_q;
        status_word[lxt_pkg::STAT_END_BIT]       = end_pend_q;
        status_word[lxt_pkg::STAT_ARMED_BIT]     = armed_q;
        status_word[lxt_pkg::STAT_RANGE_BIT]     = range_bad;
        status_word[lxt_pkg::STAT_LINES_LSB +: 3] = line_level;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_read) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == lxt_pkg::CTRL_OFFSET) begin
            reg_rdata <= {26'h0, origin_q, 1'b0, falling_edge_q, pulse_mode_q, trig_enable_q};
        end else if (reg_addr == lxt_pkg::COUNT_OFFSET) begin
            reg_rdata <= {20'h0, count_q};
        end else if (reg_addr == lxt_pkg::DURATION_OFFSET) begin
            reg_rdata <= 32'(count_q) * 32'(lxt_pkg::ABS_UNITS_PER_TICK);
        end else if (reg_addr == lxt_pkg::STATUS_OFFSET) begin
            reg_rdata <= status_word;
        end else if (rd_slot != 2'h3) begin
            reg_rdata <= {20'h0, debounce_q[rd_slot]};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : lxt_exposure

`default_nettype wire

// ---- test/lxt_exposure_monitor.sv ----
// Concurrent checks on the ports of the line exposure timing block.
`timescale 1ns/10ps
`default_nettype none

module lxt_exposure_monitor (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // Line starts
    input wire logic        internal_line_start,
    input wire logic [2:0]  external_line_trigger,
    // Exposure window
    input wire logic        exposure_active,
    input wire logic        exposure_start,
    input wire logic        exposure_end
);
    logic trig_en_q;

    // Shadow of the trigger enable, so internal starts can be judged.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trig_en_q <= 1'b0;
        end else if (reg_write && reg_addr == lxt_pkg::CTRL_OFFSET) begin
            trig_en_q <= reg_wdata[lxt_pkg::TRIG_ENABLE_BIT];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_count_read;
        reg_read && !reg_write && reg_addr == lxt_pkg::COUNT_OFFSET;
    endsequence
    sequence s_dur_read;
        reg_read && !reg_write && reg_addr == lxt_pkg::DURATION_OFFSET;
    endsequence
    property p_dur_tracks;
        logic [31:0] v;
        s_count_read ##1 (s_dur_read, v = reg_rdata) |=> reg_rdata == v * 32'd10;
    endproperty

    ////////////////////////////////////////////////////////////
    // start and end pulses, register read-back, window opening after an internal line start
    a_start_after_rise: assert property ($rose(exposure_active) |-> exposure_start)
        else $error("start pulse missing after window opened");
    a_start_cause: assert property (
        exposure_start |-> exposure_active && !$past(exposure_active))
        else $error("start pulse without a fresh window");
    a_end_after_fall: assert property ($fell(exposure_active) |-> exposure_end)
        else $error("end pulse missing after window closed");
    a_pulses_apart: assert property (exposure_start |-> !exposure_end)
        else $error("start and end pulse together");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_count_range: assert property (
        $past(reg_read) && $past(reg_addr) == lxt_pkg::COUNT_OFFSET
        |-> reg_rdata[11:0] != 12'h0 && reg_rdata[31:12] == 20'h0)
        else $error("exposure count outside 1 to 4095");
    a_dur_grid: assert property (
        $past(reg_read) && $past(reg_addr) == lxt_pkg::DURATION_OFFSET
        |-> reg_rdata % 32'd10 == 32'h0 && reg_rdata <= 32'd40950)
        else $error("duration off the 100 ns grid");
    a_dur_tracks: assert property (p_dur_tracks)
        else $error("duration does not match count");
    a_timed_start: assert property (
        internal_line_start && !trig_en_q && !exposure_active && !exposure_end
        |-> ##[1:3] $rose(exposure_active))
        else $error("internal line start did not open a window");
endmodule : lxt_exposure_monitor

bind lxt_exposure lxt_exposure_monitor u_monitor (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .internal_line_start(internal_line_start), .external_line_trigger(external_line_trigger),
    .exposure_active(exposure_active), .exposure_start(exposure_start),
    .exposure_end(exposure_end));

`default_nettype wire

// ---- test/lxt_trigger_src.sv ----
// Model of the external line trigger source on input line 1.
`timescale 1ns/10ps
`default_nettype none

module lxt_trigger_src (
    // Clock
    input  wire logic        core_clk,
    // Pulse request
    input  wire logic        fire,
    input  wire logic [15:0] width,
    input  wire logic        idle_high,
    // Trigger pin
    output logic             line_out
);
    int left = 0;

    always @(posedge core_clk) begin
        if (fire && left == 0)
            left <= (width < 16'd500) ? 500 : int'(width);
        else if (left > 0)
            left <= left - 1;
    end

    assign line_out = (left > 0) ? !idle_high : idle_high;
endmodule : lxt_trigger_src

`default_nettype wire

// ---- test/lxt_exposure_tb_top.sv ----
// Self-checking bench of the line exposure timing block.
`timescale 1ns/10ps
`default_nettype none

module lxt_exposure_tb_top;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic        internal_line_start = 1'b0;
    logic [1:0]  noise = 2'h0;
    logic        line1;
    logic        fire = 1'b0;
    logic        idle_high = 1'b0;
    logic [15:0] width = 16'd600;
    logic        exposure_active;
    logic        exposure_start;
    logic        exposure_end;
    logic        rd_seen = 1'b0;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          t_req = 0;
    int          t_s = 0;
    int          seed = 73750;
    int          q_exp[$];
    int          q_tol[$];

    always #2 core_clk = ~core_clk;

    lxt_exposure dut (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .internal_line_start(internal_line_start), .external_line_trigger({noise, line1}),
        .exposure_active(exposure_active), .exposure_start(exposure_start),
        .exposure_end(exposure_end));

    lxt_trigger_src src (.core_clk(core_clk), .fire(fire), .width(width),
        .idle_high(idle_high), .line_out(line1));

    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input int exp, input int tol);
        checks_done++;
        if ((seen + tol >= exp && seen <= exp + tol) !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t seen %0d expected %0d", $time, seen, exp);
        end
    endtask : check

    task automatic take(input logic [31:0] seen);
        if (q_exp.size() == 0) begin
            n_fail++;
            $display("ERROR %0t unexpected result %0d", $time, seen);
        end else begin
            check(seen, q_exp.pop_front(), q_tol.pop_front());
        end
    endtask : take

    task automatic expect_v(input int exp, input int tol);
        q_exp.push_back(exp);
        q_tol.push_back(tol);
    endtask : expect_v

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input int exp);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        reg_addr <= a;
        expect_v(exp, 0);
    endtask : rd

    task automatic idle(input int n);
        @(posedge core_clk);
        reg_read <= 1'b0;
        internal_line_start <= 1'b0;
        fire <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle

    // A negative delay means no window may open at all.
    // Source 0 is the internal start, 1 the line model, 2 the software command.
    task automatic shot(input logic [1:0] ext, input int dly, input int dt, input int len,
                        input int lt);
        idle(1);
        if (ext == 2'h2)
            wr(lxt_pkg::COMMAND_OFFSET, 32'h1);
        else if (ext == 2'h1)
            fire <= 1'b1;
        else
            internal_line_start <= 1'b1;
        t_req <= cyc;
        if (dly >= 0) begin
            expect_v(dly, dt);
            expect_v(len, lt);
        end
        idle(0);
        repeat (20000) if (q_exp.size() != 0) @(posedge core_clk);
        idle(100);
    endtask : shot

    ////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        noise <= 2'($random(seed));
    end

    // Results are taken in the cycle they show on the ports; read data shows one cycle after the read.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rd_seen <= reg_read;
        if (rd_seen)
            take(reg_rdata);
        if (exposure_start) begin
            t_s <= cyc;
            take(32'(cyc - t_req));
        end
        if (exposure_end)
            take(32'(cyc - t_s));
    end

    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end

    initial begin
        int v;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        rd(lxt_pkg::CTRL_OFFSET, 32'h10);
        rd(lxt_pkg::COUNT_OFFSET, 32'h1f4);
        rd(lxt_pkg::DURATION_OFFSET, 32'd5000);
        rd(lxt_pkg::DEBOUNCE_BASE_OFFSET, 32'h0);
        rd(8'h24, 32'h0);
        wr(lxt_pkg::COUNT_OFFSET, 32'h0);
        rd(lxt_pkg::COUNT_OFFSET, 32'h1);
        rd(lxt_pkg::DURATION_OFFSET, 32'd10);
        wr(lxt_pkg::COUNT_OFFSET, 32'h1000);
        rd(lxt_pkg::COUNT_OFFSET, 32'hfff);
        rd(lxt_pkg::DURATION_OFFSET, 32'd40950);
        for (int i = 0; i < 4; i++) begin
            v = 1 + ($unsigned($random(seed)) % 4095);
            wr(lxt_pkg::COUNT_OFFSET, 32'(v));
            rd(lxt_pkg::COUNT_OFFSET, v);
            rd(lxt_pkg::DURATION_OFFSET, v * 10);
        end
        wr(lxt_pkg::DURATION_OFFSET, 32'd12346);
        rd(lxt_pkg::COUNT_OFFSET, 1235);
        rd(lxt_pkg::DURATION_OFFSET, 12350);
        wr(lxt_pkg::DURATION_OFFSET, 32'd12344);
        rd(lxt_pkg::DURATION_OFFSET, 12340);
        wr(lxt_pkg::COUNT_OFFSET, 32'd30);
        shot(1'b0, 4, 1, 738, 14);
        wr(lxt_pkg::CTRL_OFFSET, 32'h11);
        shot(1'b0, -1, 0, 0, 0);
        wr(lxt_pkg::CTRL_OFFSET, 32'h01);
        shot(2'h2, 4, 1, 738, 14);
        wr(lxt_pkg::CTRL_OFFSET, 32'h11);
        shot(1'b1, 393, 16, 675, 2);
        wr(lxt_pkg::DEBOUNCE_BASE_OFFSET, 32'h4);
        shot(1'b1, 493, 16, 675, 2);
        wr(lxt_pkg::DEBOUNCE_BASE_OFFSET, 32'h2);
        wr(lxt_pkg::CTRL_OFFSET, 32'h17);
        idle_high <= 1'b1;
        width <= 16'd800;
        shot(1'b1, 443, 16, 725, 27);
        width <= 16'd3000;
        shot(1'b1, 443, 16, 2925, 27);
        if (q_exp.size() != 0)
            n_fail++;
        print_verdict();
    end
endmodule : lxt_exposure_tb_top

`default_nettype wire
